// ==== dap_pkg.sv ====
// shared constants and types for the dual-array write and poll host controller
package dap_pkg;

    // ------------------------------------------------------------
    // widths and clock
    // ------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int CLK_PERIOD_NS = 40;

    // ------------------------------------------------------------
    // pin timing, as printed, and derived cycle counts
    // ------------------------------------------------------------
    localparam int T_WP_NS = 100;
    localparam int T_WPH_NS = 100;
    localparam int T_ACC_NS = 150;
    localparam int T_CED_NS = 100;
    localparam int T_BLC_US = 150;
    localparam int T_WC_MS = 10;
    // least times round up
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CED_CYC = (T_CED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest times round down
    localparam int BLC_CYC = (T_BLC_US * 1000) / CLK_PERIOD_NS;
    localparam int WC_CYC = (T_WC_MS * 1000000) / CLK_PERIOD_NS;
    // last safe launch point inside the byte-load window
    localparam logic [11:0] BLC_LIMIT = 12'(BLC_CYC - WP_CYC - 1);
    // a flash read in the window must return with room for the next load
    localparam logic [11:0] READ_LIMIT = 12'(BLC_CYC - WP_CYC - ACC_CYC - CED_CYC - 4);

    // ------------------------------------------------------------
    // unlock and command bytes, array geometry
    // ------------------------------------------------------------
    localparam logic [18:0] UNLK_ADDR_A = 19'h05555;
    localparam logic [18:0] UNLK_ADDR_B = 19'h02AAA;
    localparam logic [7:0] UNLK_DATA_A = 8'hAA;
    localparam logic [7:0] UNLK_DATA_B = 8'h55;
    localparam logic [7:0] CMD_WRITE = 8'hA0;
    localparam logic [7:0] CMD_ID_ENTER = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [1:0] UNLK_LAST_STEP = 2'h2;
    localparam logic [7:0] FLASH_LAST_IDX = 8'hFF;
    localparam logic [7:0] EEP_LAST_IDX = 8'h0F;
    localparam logic [18:0] EEP_ADDR_MASK = 19'h07FFF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_RD_FLASH = 3'h0,
        OP_RD_EEP = 3'h1,
        OP_WR_FLASH = 3'h2,
        OP_WR_EEP = 3'h3,
        OP_ID_ENTER = 3'h4,
        OP_ID_EXIT = 3'h5
    } dap_op_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_UNLK = 8'h02,
        ST_LOAD = 8'h04,
        ST_WLOW = 8'h08,
        ST_WHIGH = 8'h10,
        ST_RLOW = 8'h20,
        ST_GAP = 8'h40,
        ST_FIN = 8'h80
    } dap_state_t;

endpackage : dap_pkg

// ==== dap_host.sv ====
// host-side controller driving a dual-array flash and eeprom memory over its pins
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01 - every write or id command starts with the three-byte unlock sequence
// RULE_02 - first byte loaded after unlock is the first destination of a sector write
// RULE_03 - eeprom writes use only the fifteen low address lines; upper ones ignored
// RULE_04 - each further byte load follows the previous within the byte-load window
// RULE_05 - device finishes its internal write within the write cycle time
// RULE_06 - flash reads may sit between eeprom byte loads while the window holds
// RULE_07 - flash read data stays valid throughout the eeprom internal write
// RULE_08 - flash and eeprom selects are never low together
// RULE_09 - during a write, bit 7 reads back as the complement of the last byte
// RULE_10 - id mode returns maker code at address bit 0 low, device code when high
// RULE_11 - device drops id mode when power is lost
// RULE_12 - after id exit sequence the device resumes normal reads and writes
// RULE_13 - flash reads during a flash internal write act as status polls
// RULE_14 - host never reads the eeprom while a flash write is in progress
// RULE_15 - polling reads the address of the last byte loaded, at any time
// RULE_16 - loading closes once no byte arrives within the byte-load window
// RULE_17 - write is complete when bit 7 matches, or after the write cycle time
module dap_host #(
    parameter int WRITE_TIMEOUT_CYC = dap_pkg::WC_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // command port
    input wire logic cmd_valid,
    input wire dap_pkg::dap_op_t cmd_op,
    input wire logic [18:0] cmd_addr,
    output logic cmd_ready,
    // write byte stream
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_last,
    output logic wr_ready,
    // results
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic timeout,
    output logic id_mode,
    // memory pins
    output logic [18:0] address,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] data_in,
    output logic flash_select_n,
    output logic eeprom_select_n,
    output logic out_enable_n,
    output logic write_strobe_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dap_pkg::dap_state_t state_r, state_nxt;
    dap_pkg::dap_op_t op_r, op_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [1:0] step_r, step_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [11:0] blc_cnt_r, blc_cnt_nxt;
    logic [17:0] wt_cnt_r, wt_cnt_nxt;
    logic [18:0] base_r, base_nxt, last_addr_r, last_addr_nxt, addr_nxt;
    logic [7:0] last_data_r, last_data_nxt, dout_nxt, sample_r, sample_nxt;
    logic cyc_flash_r, cyc_flash_nxt, phase_data_r, phase_data_nxt;
    logic last_r, last_nxt, poll_r, poll_nxt, ret_load_r, ret_load_nxt;
    logic id_mode_nxt, timeout_nxt, rd_valid_nxt, done_nxt;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire is_write = (op_r == dap_pkg::OP_WR_FLASH) || (op_r == dap_pkg::OP_WR_EEP);
    wire is_eep_wr = (op_r == dap_pkg::OP_WR_EEP);
    wire cnt_done = (cnt_r == 3'h0);
    wire byte_take = (state_r == dap_pkg::ST_LOAD) && wr_valid && wr_ready;
    wire window_out = (blc_cnt_r >= dap_pkg::BLC_LIMIT); // [RULE_04]
    wire [7:0] last_idx = is_eep_wr ? dap_pkg::EEP_LAST_IDX : dap_pkg::FLASH_LAST_IDX;
    wire [18:0] load_addr_raw = base_r + {11'h000, idx_r};
    // upper lines held low, the array would ignore them anyway
    wire [18:0] load_addr = is_eep_wr ? (load_addr_raw & dap_pkg::EEP_ADDR_MASK)
                                      : load_addr_raw; // [RULE_03]
    wire [7:0] cmd_byte = (op_r == dap_pkg::OP_ID_ENTER) ? dap_pkg::CMD_ID_ENTER :
                          (op_r == dap_pkg::OP_ID_EXIT) ? dap_pkg::CMD_ID_EXIT :
                          dap_pkg::CMD_WRITE;
    // only a flash read may slip between eeprom byte loads
    wire cmd_take = cmd_valid && cmd_ready && ((state_r == dap_pkg::ST_IDLE) ||
                    (cmd_op == dap_pkg::OP_RD_FLASH && !byte_take)); // [RULE_06] [RULE_14]
    wire poll_ok = (sample_r[7] == last_data_r[7]);
    wire wt_out = (wt_cnt_r >= 18'(WRITE_TIMEOUT_CYC));
    wire bus_low = (state_nxt == dap_pkg::ST_WLOW) || (state_nxt == dap_pkg::ST_RLOW);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        cnt_nxt = cnt_done ? 3'h0 : cnt_r - 3'h1;
        step_nxt = step_r;
        idx_nxt = idx_r;
        blc_cnt_nxt = (blc_cnt_r == 12'hFFF) ? blc_cnt_r : blc_cnt_r + 12'h001;
        wt_cnt_nxt = (wt_cnt_r == 18'h3FFFF) ? wt_cnt_r : wt_cnt_r + 18'h00001;
        base_nxt = base_r;
        last_addr_nxt = last_addr_r;
        last_data_nxt = last_data_r;
        addr_nxt = address;
        dout_nxt = data_out;
        sample_nxt = sample_r;
        cyc_flash_nxt = cyc_flash_r;
        phase_data_nxt = phase_data_r;
        last_nxt = last_r;
        poll_nxt = poll_r;
        ret_load_nxt = ret_load_r;
        id_mode_nxt = id_mode;
        timeout_nxt = timeout;
        rd_valid_nxt = 1'b0;
        done_nxt = 1'b0;
        case (state_r)
            dap_pkg::ST_IDLE: begin
                if (cmd_take) begin
                    op_nxt = cmd_op;
                    base_nxt = cmd_addr;
                    idx_nxt = 8'h00;
                    step_nxt = 2'h0;
                    poll_nxt = 1'b0;
                    ret_load_nxt = 1'b0;
                    timeout_nxt = 1'b0;
                    if (cmd_op == dap_pkg::OP_RD_FLASH || cmd_op == dap_pkg::OP_RD_EEP) begin
                        addr_nxt = cmd_addr;
                        cyc_flash_nxt = (cmd_op == dap_pkg::OP_RD_FLASH);
                        cnt_nxt = 3'(dap_pkg::ACC_CYC - 1);
                        state_nxt = dap_pkg::ST_RLOW;
                    end else begin
                        state_nxt = dap_pkg::ST_UNLK;
                    end
                end
            end
            dap_pkg::ST_UNLK: begin
                addr_nxt = (step_r == 2'h1) ? dap_pkg::UNLK_ADDR_B : dap_pkg::UNLK_ADDR_A;
                dout_nxt = (step_r == 2'h0) ? dap_pkg::UNLK_DATA_A :
                           (step_r == 2'h1) ? dap_pkg::UNLK_DATA_B : cmd_byte; // [RULE_01]
                cyc_flash_nxt = !is_eep_wr;
                phase_data_nxt = 1'b0;
                cnt_nxt = 3'(dap_pkg::WP_CYC - 1);
                state_nxt = dap_pkg::ST_WLOW;
            end
            dap_pkg::ST_LOAD: begin
                if (byte_take) begin
                    // first byte lands at the command address
                    addr_nxt = load_addr; // [RULE_02]
                    dout_nxt = wr_data;
                    last_addr_nxt = load_addr;
                    last_data_nxt = wr_data;
                    last_nxt = wr_last || (idx_r == last_idx);
                    cyc_flash_nxt = !is_eep_wr;
                    phase_data_nxt = 1'b1;
                    blc_cnt_nxt = 12'h000;
                    cnt_nxt = 3'(dap_pkg::WP_CYC - 1);
                    state_nxt = dap_pkg::ST_WLOW;
                end else if (window_out) begin
                    // stalled source: close loading and poll what was loaded
                    poll_nxt = (idx_r != 8'h00); // [RULE_16]
                    timeout_nxt = (idx_r == 8'h00);
                    wt_cnt_nxt = 18'h00000;
                    addr_nxt = last_addr_r;
                    cyc_flash_nxt = !is_eep_wr;
                    cnt_nxt = 3'(dap_pkg::ACC_CYC - 1);
                    state_nxt = (idx_r != 8'h00) ? dap_pkg::ST_RLOW : dap_pkg::ST_FIN;
                end else if (cmd_take) begin
                    addr_nxt = cmd_addr;
                    cyc_flash_nxt = 1'b1;
                    ret_load_nxt = 1'b1; // [RULE_06]
                    cnt_nxt = 3'(dap_pkg::ACC_CYC - 1);
                    state_nxt = dap_pkg::ST_RLOW;
                end
            end
            dap_pkg::ST_WLOW: begin
                if (cnt_done) begin
                    cnt_nxt = 3'(dap_pkg::WPH_CYC - 1);
                    state_nxt = dap_pkg::ST_WHIGH;
                end
            end
            dap_pkg::ST_WHIGH: begin
                if (cnt_done && !phase_data_r) begin
                    if (step_r != dap_pkg::UNLK_LAST_STEP) begin
                        step_nxt = step_r + 2'h1;
                        state_nxt = dap_pkg::ST_UNLK;
                    end else if (is_write) begin
                        blc_cnt_nxt = 12'h000;
                        state_nxt = dap_pkg::ST_LOAD;
                    end else begin
                        id_mode_nxt = (op_r == dap_pkg::OP_ID_ENTER);
                        state_nxt = dap_pkg::ST_FIN;
                    end
                end else if (cnt_done) begin
                    idx_nxt = idx_r + 8'h01;
                    if (last_r) begin
                        // poll the last loaded address right away
                        poll_nxt = 1'b1; // [RULE_15]
                        wt_cnt_nxt = 18'h00000;
                        addr_nxt = last_addr_r;
                        cnt_nxt = 3'(dap_pkg::ACC_CYC - 1);
                        state_nxt = dap_pkg::ST_RLOW;
                    end else begin
                        state_nxt = dap_pkg::ST_LOAD;
                    end
                end
            end
            dap_pkg::ST_RLOW: begin
                if (cnt_done) begin
                    sample_nxt = data_in;
                    cnt_nxt = 3'(dap_pkg::CED_CYC - 1);
                    state_nxt = dap_pkg::ST_GAP;
                end
            end
            dap_pkg::ST_GAP: begin
                // selects stay high here, so switching arrays keeps its delay
                if (cnt_done && poll_r) begin
                    if (poll_ok || wt_out) begin
                        timeout_nxt = !poll_ok; // [RULE_17]
                        state_nxt = dap_pkg::ST_FIN;
                    end else begin
                        addr_nxt = last_addr_r;
                        cnt_nxt = 3'(dap_pkg::ACC_CYC - 1);
                        state_nxt = dap_pkg::ST_RLOW;
                    end
                end else if (cnt_done) begin
                    rd_valid_nxt = 1'b1;
                    ret_load_nxt = 1'b0;
                    state_nxt = ret_load_r ? dap_pkg::ST_LOAD : dap_pkg::ST_FIN;
                end
            end
            dap_pkg::ST_FIN: begin
                done_nxt = 1'b1;
                state_nxt = dap_pkg::ST_IDLE;
            end
            default: state_nxt = dap_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= dap_pkg::ST_IDLE;
            op_r <= dap_pkg::OP_RD_FLASH;
            {cnt_r, step_r, idx_r, blc_cnt_r, wt_cnt_r} <= '0;
            {base_r, last_addr_r, last_data_r, sample_r} <= '0;
            {cyc_flash_r, phase_data_r, last_r, poll_r, ret_load_r} <= '0;
            {address, data_out, rd_data, rd_valid, done, timeout, id_mode} <= '0;
            {cmd_ready, wr_ready} <= '0;
            {data_oe_n, flash_select_n, eeprom_select_n, out_enable_n} <= 4'hF;
            write_strobe_n <= 1'b1;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            {cnt_r, step_r, idx_r, blc_cnt_r, wt_cnt_r} <=
                {cnt_nxt, step_nxt, idx_nxt, blc_cnt_nxt, wt_cnt_nxt};
            {base_r, last_addr_r, last_data_r, sample_r} <=
                {base_nxt, last_addr_nxt, last_data_nxt, sample_nxt};
            {cyc_flash_r, phase_data_r, last_r, poll_r, ret_load_r} <=
                {cyc_flash_nxt, phase_data_nxt, last_nxt, poll_nxt, ret_load_nxt};
            {address, data_out, timeout, id_mode} <= {addr_nxt, dout_nxt, timeout_nxt, id_mode_nxt};
            rd_data <= rd_valid_nxt ? sample_r : rd_data;
            rd_valid <= rd_valid_nxt;
            done <= done_nxt;
            cmd_ready <= (state_nxt == dap_pkg::ST_IDLE) || ((state_nxt == dap_pkg::ST_LOAD)
                         && is_eep_wr && (blc_cnt_nxt < dap_pkg::READ_LIMIT));
            wr_ready <= (state_nxt == dap_pkg::ST_LOAD);
            data_oe_n <= !((state_nxt == dap_pkg::ST_WLOW) || (state_nxt == dap_pkg::ST_WHIGH));
            flash_select_n <= !(bus_low && cyc_flash_nxt); // [RULE_08]
            eeprom_select_n <= !(bus_low && !cyc_flash_nxt); // [RULE_08]
            out_enable_n <= (state_nxt != dap_pkg::ST_RLOW);
            write_strobe_n <= (state_nxt != dap_pkg::ST_WLOW);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [3:0] stb_cnt_r;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stb_cnt_r <= 4'h0;
        end else if (state_r == dap_pkg::ST_IDLE) begin
            stb_cnt_r <= 4'h0;
        end else if (write_strobe_n && state_nxt == dap_pkg::ST_WLOW) begin
            stb_cnt_r <= stb_cnt_r + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_pulse_tail;
        !write_strobe_n [*3] ##1 write_strobe_n;
    endsequence

    chk_unlock_first: assert property ( // [RULE_01]
        ($rose(wr_ready) && idx_r == 8'h00) |-> stb_cnt_r == 4'h3)
        else $error("byte load offered without three unlock writes");
    chk_strobe_width: assert property ($fell(write_strobe_n) |-> s_pulse_tail)
        else $error("write strobe width wrong");
    chk_eep_upper: assert property ( // [RULE_03]
        (!write_strobe_n && !eeprom_select_n) |-> address[18:15] == 4'h0)
        else $error("eeprom write with upper address lines set");
    chk_load_window: assert property ( // [RULE_04]
        byte_take |-> blc_cnt_r < 12'(dap_pkg::BLC_CYC))
        else $error("byte load later than the window");
    chk_read_between: assert property ( // [RULE_06]
        ($past(state_r) == dap_pkg::ST_GAP && state_r == dap_pkg::ST_LOAD)
        |-> blc_cnt_r <= dap_pkg::BLC_LIMIT)
        else $error("flash read overran the byte-load window");
    chk_select_excl: assert property (!(!flash_select_n && !eeprom_select_n)) // [RULE_08]
        else $error("both selects low");
    chk_select_gap: assert property ( // [RULE_08]
        $fell(flash_select_n) |-> $past(eeprom_select_n, 1) && $past(eeprom_select_n, 3))
        else $error("flash select too soon after eeprom select");
    chk_no_eep_read: assert property ( // [RULE_14]
        (op_r == dap_pkg::OP_WR_FLASH && state_r != dap_pkg::ST_IDLE) |-> eeprom_select_n)
        else $error("eeprom touched during flash write");
    chk_poll_addr: assert property ( // [RULE_15]
        (poll_r && !out_enable_n) |-> address == last_addr_r)
        else $error("poll read off the last loaded address");
    chk_done_match: assert property ( // [RULE_17]
        (done && is_write && !timeout) |-> sample_r[7] == last_data_r[7])
        else $error("write reported done before bit 7 matched");

endmodule : dap_host

`default_nettype wire

// ==== dap_mem_model.sv ====
// pin-level behavioural model of the dual-array memory
`timescale 1ns/1ps
`default_nettype none
module dap_mem_model #(
    parameter int BLC_CYC = 3750,
    parameter int WR_CYC = 300,
    parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary
    parameter logic [7:0] DEVICE_CODE = 8'hC3 // arbitrary
) (
    // model sampling clock
    input wire logic clock,
    // memory pins
    input wire logic [18:0] address,
    input wire logic [7:0] data_out,
    input wire logic flash_select_n,
    input wire logic eeprom_select_n,
    input wire logic out_enable_n,
    input wire logic write_strobe_n,
    output logic [7:0] data_in
);
    logic [7:0] flash_a [int];
    logic [7:0] eep_a [int];
    int pend_a [$];
    logic [7:0] pend_d [$];
    int step = 0, mode = 0, tmr = 0;
    bit tgt_eep, seen = 0, wr_eep, id_on = 0; // power-up never in id mode
    logic [18:0] wr_a;
    logic [7:0] wr_d, last_d = 8'h00;
    initial data_in = 8'h00;

    function automatic logic [7:0] peek(bit e, logic [18:0] a);
        if (e) return eep_a.exists(int'(a[14:0])) ? eep_a[int'(a[14:0])] : a[7:0] ^ 8'hA5;
        return flash_a.exists(int'(a)) ? flash_a[int'(a)] : a[7:0] ^ a[15:8];
    endfunction : peek

    // ------------------------------------------------------------
    // byte loads, unlock decode, write cycle
    // ------------------------------------------------------------
    task automatic take(bit e, logic [18:0] a, logic [7:0] d);
        logic [18:0] k;
        k = a & dap_pkg::EEP_ADDR_MASK;
        if (mode == 1 && e == tgt_eep) begin
            pend_a.push_back(e ? int'(k) : int'(a));
            pend_d.push_back(d);
            last_d = d;
            tmr = 0;
        end else if (mode == 0) begin
            if (step == 0 && k == dap_pkg::UNLK_ADDR_A && d == dap_pkg::UNLK_DATA_A) step = 1;
            else if (step == 1 && k == dap_pkg::UNLK_ADDR_B && d == dap_pkg::UNLK_DATA_B) step = 2;
            else if (step == 2 && k == dap_pkg::UNLK_ADDR_A) begin
                step = 0;
                if (d == dap_pkg::CMD_WRITE) begin
                    mode = 1;
                    tmr = 0;
                    tgt_eep = e;
                end
                if (d == dap_pkg::CMD_ID_ENTER) id_on = 1;
                if (d == dap_pkg::CMD_ID_EXIT) id_on = 0;
            end else step = 0;
        end
    endtask : take

    always @(negedge clock) begin
        if (!write_strobe_n && !(flash_select_n && eeprom_select_n)) begin
            seen = 1;
            wr_eep = !eeprom_select_n;
            wr_a = address;
            wr_d = data_out;
        end else if (seen) begin
            seen = 0;
            take(wr_eep, wr_a, wr_d);
        end
        tmr++;
        if (mode == 1 && tmr >= BLC_CYC) begin // silence closes loading
            mode = pend_a.size() ? 2 : 0;
            tmr = 0;
        end else if (mode == 2 && tmr >= WR_CYC) begin // bounded write time
            foreach (pend_a[i]) begin
                if (tgt_eep) eep_a[pend_a[i]] = pend_d[i];
                else flash_a[pend_a[i]] = pend_d[i];
            end
            pend_a.delete();
            pend_d.delete();
            mode = 0;
        end
        // undriven bus shows a moving pattern, never a held value
        if (out_enable_n || !write_strobe_n || !(flash_select_n ^ eeprom_select_n))
            data_in = ~data_in;
        else if (mode != 0 && !eeprom_select_n == tgt_eep)
            data_in = {~last_d[7], last_d[6:0]};
        else if (id_on && eeprom_select_n && address[18:1] == 18'h0)
            data_in = address[0] ? DEVICE_CODE : MAKER_CODE;
        else
            data_in = peek(!eeprom_select_n, address);
    end
endmodule : dap_mem_model
`default_nettype wire

// ==== dap_host_bench.sv ====
// self-checking bench for the dual-array host controller
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module dap_host_bench;
    localparam logic [7:0] MAKER_CODE = 8'h3C; // arbitrary
    localparam logic [7:0] DEVICE_CODE = 8'hC3; // arbitrary
    logic clock, arst_n, cmd_valid, wr_valid, wr_last, cmd_ready, wr_ready, rd_valid, done;
    logic timeout, id_mode, data_oe_n, flash_select_n, eeprom_select_n, out_enable_n;
    logic write_strobe_n;
    dap_pkg::dap_op_t cmd_op;
    logic [18:0] cmd_addr, address, base;
    logic [7:0] wr_data, rd_data, data_out, data_in, got, d;
    logic [7:0] fm [int];
    logic [7:0] em [int];
    int err_count = 0, num_checks = 0, seed = 49, n;

    dap_host #(.WRITE_TIMEOUT_CYC(20000)) i_dap_host (.clock(clock), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_last(wr_last), .wr_ready(wr_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .timeout(timeout),
        .id_mode(id_mode), .address(address), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .flash_select_n(flash_select_n), .eeprom_select_n(eeprom_select_n),
        .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n));
    dap_mem_model #(.BLC_CYC(dap_pkg::BLC_CYC), .WR_CYC(300), .MAKER_CODE(MAKER_CODE),
        .DEVICE_CODE(DEVICE_CODE)) i_dap_mem_model (.clock(clock), .address(address),
        .data_out(data_out), .flash_select_n(flash_select_n), .data_in(data_in),
        .eeprom_select_n(eeprom_select_n), .out_enable_n(out_enable_n),
        .write_strobe_n(write_strobe_n));

    // ------------------------------------------------------------
    // reference model and bus tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] expect_rd(bit e, logic [18:0] a);
        if (e) return em.exists(int'(a[14:0])) ? em[int'(a[14:0])] : a[7:0] ^ 8'hA5;
        return fm.exists(int'(a)) ? fm[int'(a)] : a[7:0] ^ a[15:8];
    endfunction : expect_rd

    task automatic results;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic stall(int k, int lim);
        if (k >= lim) begin
            err_count++;
            results();
        end
    endtask : stall

    task automatic issue(dap_pkg::dap_op_t op, logic [18:0] a);
        int k;
        cmd_op = op;
        cmd_addr = a;
        cmd_valid = 1'b1;
        for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clock);
        stall(k, 100);
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask : issue

    task automatic wait_done(output int k);
        // a read between byte loads answers with rd_valid alone, so stop on either pulse
        for (k = 0; k < 30000 && done !== 1'b1 && rd_valid !== 1'b1; k++) @(negedge clock);
        got = rd_data;
        stall(k, 30000);
    endtask : wait_done

    task automatic rd(bit e, logic [18:0] a);
        issue(e ? dap_pkg::OP_RD_EEP : dap_pkg::OP_RD_FLASH, a);
        wait_done(n);
    endtask : rd

    task automatic put(logic [7:0] v, bit last);
        int k;
        wr_data = v;
        wr_last = last;
        wr_valid = 1'b1;
        for (k = 0; k < 100 && wr_ready !== 1'b1; k++) @(negedge clock);
        stall(k, 100);
        @(negedge clock);
        {wr_valid, wr_last} = 2'h0;
        @(negedge clock);
    endtask : put

    always @(negedge clock) begin
        if (arst_n === 1'b1) `CHECK({flash_select_n | eeprom_select_n, write_strobe_n | !data_oe_n,
            out_enable_n | data_oe_n}, 3'h7)
    end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = dap_pkg::OP_RD_FLASH;
        cmd_addr = '0;
        wr_valid = 1'b0;
        wr_data = '0;
        wr_last = 1'b0;
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        // eeprom page with upper address bits set and a flash read between loads
        base = {4'hA, 11'($random(seed)), 4'h0};
        issue(dap_pkg::OP_WR_EEP, base);
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            em[int'(base[14:0]) + i] = d;
            put(d, i == 5);
            if (i == 2) begin
                rd(1'b0, 19'($random(seed)));
                `CHECK(got, expect_rd(1'b0, cmd_addr))
            end
        end
        wait_done(n);
        `CHECK(timeout, 1'b0)
        `CHECK(n > dap_pkg::BLC_CYC, 1'b1)
        for (int i = 0; i < 6; i++) begin
            rd(1'b1, {4'h0, base[14:0]} + 19'(i));
            `CHECK(got, expect_rd(1'b1, cmd_addr))
        end
        // short flash sector; one byte past it must stay untouched
        base = {11'($random(seed)), 8'h10};
        issue(dap_pkg::OP_WR_FLASH, base);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            fm[int'(base) + i] = d;
            put(d, i == 3);
        end
        wait_done(n);
        `CHECK(timeout, 1'b0)
        for (int i = 0; i < 5; i++) begin
            rd(1'b0, base + 19'(i));
            `CHECK(got, expect_rd(1'b0, cmd_addr))
        end
        // unlock with nothing loaded; let the device window lapse afterwards
        issue(dap_pkg::OP_WR_FLASH, base);
        wait_done(n);
        `CHECK(timeout, 1'b1)
        repeat (20) @(negedge clock);
        issue(dap_pkg::OP_ID_ENTER, '0);
        wait_done(n);
        `CHECK(id_mode, 1'b1)
        for (int i = 0; i < 2; i++) begin
            rd(1'b0, 19'(i));
            `CHECK(got, i ? DEVICE_CODE : MAKER_CODE)
        end
        issue(dap_pkg::OP_ID_EXIT, '0);
        wait_done(n);
        `CHECK(id_mode, 1'b0)
        for (int i = 0; i < 2; i++) begin
            rd(1'b0, 19'(i));
            `CHECK(got, expect_rd(1'b0, cmd_addr))
        end
        results();
    end
endmodule : dap_host_bench
`default_nettype wire
